// >>> hdl/mb_pkg.sv
// Constants, state type and checksum of the frame handler
`default_nettype none
package mb_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Function, sub-function and control codes
  localparam logic [7:0] FN_WRITE_MULTI = 8'h10;
  localparam logic [7:0] FN_SPECIAL     = 8'h09;
  localparam logic [7:0] SUB_REMOTE     = 8'h30;
  localparam logic [7:0] CTL_START      = 8'h1a;
  localparam logic [7:0] CTL_STOP       = 8'h1b;

  //////////////////////////////////////////////////////////////////////////
  // Exception codes and flag
  localparam logic [7:0] EXC_FLAG       = 8'h80;
  localparam logic [7:0] EXC_ILL_FUNC   = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR   = 8'h02;
  localparam logic [7:0] EXC_ILL_DATA   = 8'h03;
  localparam logic [7:0] EXC_BUSY       = 8'h06;
  localparam logic [7:0] EXC_NAK        = 8'h07;
  localparam logic [7:0] EXC_ILL_LEN    = 8'h10;

  //////////////////////////////////////////////////////////////////////////
  // Frame layout
  localparam logic [15:0] MAX_REGS       = 16'h007d;
  localparam logic [8:0]  HDR_LEN        = 9'h007;
  localparam logic [8:0]  WMR_FIXED_LEN  = 9'h009;
  localparam logic [8:0]  SPECIAL_LEN    = 9'h006;
  localparam logic [8:0]  MIN_LEN        = 9'h004;
  localparam logic [8:0]  LEN_MAX        = 9'h1ff;
  localparam logic [2:0]  WMR_RESP_LEN   = 3'h6;
  localparam logic [2:0]  SPEC_RESP_LEN  = 3'h4;
  localparam logic [2:0]  EXC_RESP_LEN   = 3'h3;

  //////////////////////////////////////////////////////////////////////////
  // Checksum
  localparam logic [15:0] CRC_INIT       = 16'hffff;
  localparam logic [15:0] CRC_POLY       = 16'ha001;

  //////////////////////////////////////////////////////////////////////////
  // Setpoint store and output queue
  localparam logic [15:0] SP_BASE_ADDR   = 16'h03e8;
  localparam logic [7:0]  SP_WINDOW      = 8'h80;
  localparam logic [7:0]  STG_BASE       = 8'h80;
  localparam logic [15:0] SP_MAX_VALUE   = 16'h2710;
  localparam logic [15:0] SP_OFF         = 16'hffff;
  localparam int          TX_WIDTH       = 8;
  localparam int          TX_DEPTH       = 8;

  typedef enum logic [1:0] {
    ST_RX    = 2'b00,
    ST_CHECK = 2'b01,
    ST_COPY  = 2'b10,
    ST_SEND  = 2'b11
  } hstate_t;

  function automatic logic [15:0] crc16_byte(input logic [15:0] crc,
                                             input logic [7:0]  b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage
`default_nettype wire

// >>> hdl/tx_fifo.sv
// Byte FIFO between reply builder and transmitter
`default_nettype none
module tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,       // System clock
  input  wire logic             i_sys_rst,   // Async reset, high
  input  wire logic [WIDTH-1:0] i_in_data,   // Write data
  input  wire logic             i_in_valid,  // Write request
  output var  logic             o_in_ready,  // Space available
  output var  logic [WIDTH-1:0] o_out_data,  // Head word
  output var  logic             o_out_valid, // Head word present
  input  wire logic             i_out_ready  // Consumer takes head
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    nxt_wr;
  logic [AW-1:0]    rd_ff;
  logic [AW-1:0]    nxt_rd;
  logic [AW:0]      cnt_ff;
  logic [AW:0]      nxt_cnt;
  logic             full_ff;
  logic             nonempty_ff;
  logic             push;
  logic             pop;

  assign push        = i_in_valid && !full_ff;
  assign pop         = nonempty_ff && i_out_ready;
  assign o_in_ready  = !full_ff;
  assign o_out_valid = nonempty_ff;
  assign o_out_data  = mem_ff[rd_ff];

  always_comb begin
    nxt_wr  = push ? wr_ff + AW'(1) : wr_ff;
    nxt_rd  = pop ? rd_ff + AW'(1) : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ff       <= '0;
      rd_ff       <= '0;
      cnt_ff      <= '0;
      full_ff     <= 1'b0;
      nonempty_ff <= 1'b0;
    end else begin
      wr_ff       <= nxt_wr;
      rd_ff       <= nxt_rd;
      cnt_ff      <= nxt_cnt;
      full_ff     <= (nxt_cnt == (AW+1)'(DEPTH));
      nonempty_ff <= (nxt_cnt != '0);
    end
  end

  // Storage carries no reset; only pointers define what is valid
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= i_in_data;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/sp_store.sv
// Setpoint and staging store, one write, two registered reads
`default_nettype none
module sp_store (
  input  wire logic        i_clk,     // System clock
  input  wire logic        i_sys_rst, // Async reset, high
  input  wire logic        i_we,      // Write strobe
  input  wire logic [7:0]  i_waddr,   // Write address
  input  wire logic [15:0] i_wdata,   // Write data
  input  wire logic [7:0]  i_raddr_a, // Read address, port a
  output var  logic [15:0] o_rdata_a, // Registered read data a
  input  wire logic [7:0]  i_raddr_b, // Read address, port b
  output var  logic [15:0] o_rdata_b  // Registered read data b
);
  logic [15:0] mem_ff [256];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_ff[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata_a <= 16'h0000;
      o_rdata_b <= 16'h0000;
    end else begin
      o_rdata_a <= mem_ff[i_raddr_a];
      o_rdata_b <= mem_ff[i_raddr_b];
    end
  end
endmodule
`default_nettype wire

// >>> hdl/modbus_slave_frame_handler.sv
// Serial slave frame handler: parse, check, commit and answer frames
//
// Functional notes
// - Function 9, sub-function 48: remote start/stop; next byte is setting
// - Setting 0x1a starts the motor, 0x1b stops it
// - Write-multiple count above 125 gives exception 16
// - Byte count is twice register count; data bytes match byte count
// - Write-multiple reply: address, function, start, count, check
// - Normal reply returns the query's function code
// - Exception reply function field is function plus 0x80
// - Exception frame: address, offset function, code, check
// - Unsupported function gives exception 01
// - Invalid register address gives exception 02
// - Invalid data value gives exception 03
// - Busy device gives exception 06; master retries later
// - Valid query that cannot be performed gives exception 07
// - Standard port sends check low byte, then high byte
// - Front port sends check high byte, then low byte
// - OFF setpoint 0xffff is stored and read back unchanged
`default_nettype none
module modbus_slave_frame_handler (
  input  wire logic        i_clk,        // 100 MHz system clock
  input  wire logic        i_sys_rst,    // Async reset, high
  input  wire logic [7:0]  i_slave_addr, // Own slave address
  input  wire logic        i_front_port, // 1: front port check order
  input  wire logic [7:0]  i_rx_data,    // Received byte
  input  wire logic        i_rx_valid,   // Received byte strobe
  input  wire logic        i_frame_end,  // Inter-frame silence seen
  input  wire logic        i_busy,       // Device busy
  input  wire logic        i_nak,        // Device cannot act now
  input  wire logic        i_tx_ready,   // Transmitter takes byte
  output var  logic [7:0]  o_tx_data,    // Byte to transmit
  output var  logic        o_tx_valid,   // Byte to transmit present
  output var  logic        o_motor_start,// Start command pulse
  output var  logic        o_motor_stop, // Stop command pulse
  input  wire logic [6:0]  i_sp_rd_addr, // Setpoint read index
  output var  logic [15:0] o_sp_rd_data  // Setpoint read value
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  mb_pkg::hstate_t state_ff;
  mb_pkg::hstate_t nxt_state;

  logic [8:0]  rx_len_ff;
  logic [8:0]  nxt_rx_len;
  logic [7:0]  hdr_ff [7];
  logic [7:0]  nxt_hdr [7];
  logic [15:0] crc_ff;
  logic [15:0] nxt_crc;
  logic [15:0] crc_d1_ff;
  logic [15:0] nxt_crc_d1;
  logic [15:0] crc_d2_ff;
  logic [15:0] nxt_crc_d2;
  logic [7:0]  prev_ff;
  logic [7:0]  nxt_prev;
  logic [7:0]  last_ff;
  logic [7:0]  nxt_last;
  logic [7:0]  data_hi_ff;
  logic [7:0]  nxt_data_hi;
  logic        bad_data_ff;
  logic        nxt_bad_data;
  logic        stg_we;
  logic [7:0]  stg_addr;
  logic [15:0] stg_data;
  logic        rx_clear;

  logic [7:0]  func_out_ff;
  logic [7:0]  nxt_func_out;
  logic [7:0]  exc_ff;
  logic [7:0]  nxt_exc;
  logic        is_exc_ff;
  logic        nxt_is_exc;
  logic [2:0]  resp_len_ff;
  logic [2:0]  nxt_resp_len;
  logic [2:0]  tx_idx_ff;
  logic [2:0]  nxt_tx_idx;
  logic [15:0] tx_crc_ff;
  logic [15:0] nxt_tx_crc;
  logic [6:0]  copy_i_ff;
  logic [6:0]  nxt_copy_i;
  logic        copy_ph_ff;
  logic        nxt_copy_ph;
  logic        start_ff;
  logic        nxt_start;
  logic        stop_ff;
  logic        nxt_stop;
  logic        copy_we;
  logic [7:0]  copy_addr;
  logic [7:0]  tx_byte;
  logic        tx_push;
  logic        fifo_ready;

  logic [15:0] reg_cnt;
  logic [15:0] start_addr;
  logic [16:0] span;
  logic        crc_ok;
  logic        addr_ok;
  logic        range_ok;
  logic [7:0]  chk_exc;
  logic        chk_drop;
  logic [15:0] rd_word_a;

  ////////////////////////////////////////////////////////////////////////////
  // Receive path: header capture, running checksum, staging of data words
  always_comb begin
    logic [8:0] didx;
    logic [15:0] word;
    didx         = rx_len_ff - mb_pkg::HDR_LEN;
    word         = {data_hi_ff, i_rx_data};
    nxt_rx_len   = rx_len_ff;
    nxt_hdr      = hdr_ff;
    nxt_crc      = crc_ff;
    nxt_crc_d1   = crc_d1_ff;
    nxt_crc_d2   = crc_d2_ff;
    nxt_prev     = prev_ff;
    nxt_last     = last_ff;
    nxt_data_hi  = data_hi_ff;
    nxt_bad_data = bad_data_ff;
    stg_we       = 1'b0;
    stg_addr     = mb_pkg::STG_BASE + {1'b0, didx[7:1]};
    stg_data     = word;
    if (rx_clear) begin
      nxt_rx_len   = 9'h000;
      nxt_crc      = mb_pkg::CRC_INIT;
      nxt_crc_d1   = mb_pkg::CRC_INIT;
      nxt_crc_d2   = mb_pkg::CRC_INIT;
      nxt_bad_data = 1'b0;
    end else if (state_ff == mb_pkg::ST_RX && i_rx_valid && !i_frame_end
                 && rx_len_ff != mb_pkg::LEN_MAX) begin
      if (rx_len_ff < mb_pkg::HDR_LEN) begin
        nxt_hdr[rx_len_ff[2:0]] = i_rx_data;
      end
      nxt_crc    = mb_pkg::crc16_byte(crc_ff, i_rx_data);
      nxt_crc_d1 = crc_ff;
      nxt_crc_d2 = crc_d1_ff;
      nxt_prev   = last_ff;
      nxt_last   = i_rx_data;
      nxt_rx_len = rx_len_ff + 9'h001;
      // Check bytes past the counted words and words past 125 are never staged
      if (rx_len_ff >= mb_pkg::HDR_LEN
          && hdr_ff[1] == mb_pkg::FN_WRITE_MULTI) begin
        if (!didx[0]) begin
          nxt_data_hi = i_rx_data;
        end else if ({8'h00, didx[8:1]} < mb_pkg::MAX_REGS
                     && {8'h00, didx[8:1]} < reg_cnt) begin
          stg_we = 1'b1;
          // OFF passes untouched; other values above the limit are bad
          if (word != mb_pkg::SP_OFF && word > mb_pkg::SP_MAX_VALUE) begin
            nxt_bad_data = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_len_ff   <= 9'h000;
      crc_ff      <= mb_pkg::CRC_INIT;
      crc_d1_ff   <= mb_pkg::CRC_INIT;
      crc_d2_ff   <= mb_pkg::CRC_INIT;
      prev_ff     <= 8'h00;
      last_ff     <= 8'h00;
      data_hi_ff  <= 8'h00;
      bad_data_ff <= 1'b0;
      for (int k = 0; k < 7; k++) begin
        hdr_ff[k] <= 8'h00;
      end
    end else begin
      rx_len_ff   <= nxt_rx_len;
      hdr_ff      <= nxt_hdr;
      crc_ff      <= nxt_crc;
      crc_d1_ff   <= nxt_crc_d1;
      crc_d2_ff   <= nxt_crc_d2;
      prev_ff     <= nxt_prev;
      last_ff     <= nxt_last;
      data_hi_ff  <= nxt_data_hi;
      bad_data_ff <= nxt_bad_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame checks
  assign reg_cnt    = {hdr_ff[4], hdr_ff[5]};
  assign start_addr = {hdr_ff[2], hdr_ff[3]};
  assign span       = {1'b0, start_addr} - {1'b0, mb_pkg::SP_BASE_ADDR}
                      + {1'b0, reg_cnt};
  assign range_ok   = start_addr >= mb_pkg::SP_BASE_ADDR
                      && span <= {9'h000, mb_pkg::SP_WINDOW};
  // Check bytes are the last two; order depends on the port
  assign crc_ok     = i_front_port ? ({prev_ff, last_ff} == crc_d2_ff)
                                   : ({last_ff, prev_ff} == crc_d2_ff);
  assign addr_ok    = hdr_ff[0] == i_slave_addr;
  assign chk_drop   = rx_len_ff < mb_pkg::MIN_LEN || !crc_ok
                      || !addr_ok;

  always_comb begin
    chk_exc = 8'h00;
    if (hdr_ff[1] == mb_pkg::FN_WRITE_MULTI) begin
      if (i_busy) begin
        chk_exc = mb_pkg::EXC_BUSY;
      end else if (reg_cnt > mb_pkg::MAX_REGS) begin
        chk_exc = mb_pkg::EXC_ILL_LEN;
      end else if (reg_cnt == 16'h0000
                   || hdr_ff[6] != {reg_cnt[6:0], 1'b0}
                   || rx_len_ff != mb_pkg::WMR_FIXED_LEN
                                   + {1'b0, hdr_ff[6]}) begin
        chk_exc = mb_pkg::EXC_ILL_DATA;
      end else if (!range_ok) begin
        chk_exc = mb_pkg::EXC_ILL_ADDR;
      end else if (bad_data_ff) begin
        chk_exc = mb_pkg::EXC_ILL_DATA;
      end else if (i_nak) begin
        chk_exc = mb_pkg::EXC_NAK;
      end
    end else if (hdr_ff[1] == mb_pkg::FN_SPECIAL) begin
      if (i_busy) begin
        chk_exc = mb_pkg::EXC_BUSY;
      end else if (rx_len_ff != mb_pkg::SPECIAL_LEN) begin
        chk_exc = mb_pkg::EXC_ILL_DATA;
      end else if (hdr_ff[2] != mb_pkg::SUB_REMOTE) begin
        chk_exc = mb_pkg::EXC_ILL_FUNC;
      end else if (hdr_ff[3] != mb_pkg::CTL_START
                   && hdr_ff[3] != mb_pkg::CTL_STOP) begin
        chk_exc = mb_pkg::EXC_ILL_DATA;
      end else if (i_nak) begin
        chk_exc = mb_pkg::EXC_NAK;
      end
    end else begin
      chk_exc = mb_pkg::EXC_ILL_FUNC;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response byte selection
  always_comb begin
    if (tx_idx_ff == resp_len_ff) begin
      tx_byte = i_front_port ? tx_crc_ff[15:8] : tx_crc_ff[7:0];
    end else if (tx_idx_ff > resp_len_ff) begin
      tx_byte = i_front_port ? tx_crc_ff[7:0] : tx_crc_ff[15:8];
    end else if (tx_idx_ff == 3'h0) begin
      tx_byte = hdr_ff[0];
    end else if (tx_idx_ff == 3'h1) begin
      tx_byte = func_out_ff;
    end else if (tx_idx_ff == 3'h2 && is_exc_ff) begin
      tx_byte = exc_ff;
    end else begin
      tx_byte = hdr_ff[tx_idx_ff];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control: check, commit staged words, send response
  assign copy_addr = {1'b0, copy_i_ff};

  always_comb begin
    nxt_state    = state_ff;
    nxt_func_out = func_out_ff;
    nxt_exc      = exc_ff;
    nxt_is_exc   = is_exc_ff;
    nxt_resp_len = resp_len_ff;
    nxt_tx_idx   = tx_idx_ff;
    nxt_tx_crc   = tx_crc_ff;
    nxt_copy_i   = copy_i_ff;
    nxt_copy_ph  = copy_ph_ff;
    nxt_start    = 1'b0;
    nxt_stop     = 1'b0;
    rx_clear     = 1'b0;
    copy_we      = 1'b0;
    tx_push      = 1'b0;
    case (state_ff)
      mb_pkg::ST_RX: begin
        if (i_frame_end) begin
          nxt_state = mb_pkg::ST_CHECK;
        end
      end
      mb_pkg::ST_CHECK: begin
        nxt_tx_idx  = 3'h0;
        nxt_tx_crc  = mb_pkg::CRC_INIT;
        nxt_copy_i  = 7'h00;
        nxt_copy_ph = 1'b0;
        if (chk_drop) begin
          rx_clear  = 1'b1;
          nxt_state = mb_pkg::ST_RX;
        end else if (chk_exc != 8'h00) begin
          nxt_func_out = hdr_ff[1] | mb_pkg::EXC_FLAG;
          nxt_exc      = chk_exc;
          nxt_is_exc   = 1'b1;
          nxt_resp_len = mb_pkg::EXC_RESP_LEN;
          nxt_state    = mb_pkg::ST_SEND;
        end else begin
          nxt_func_out = hdr_ff[1];
          nxt_is_exc   = 1'b0;
          if (hdr_ff[1] == mb_pkg::FN_WRITE_MULTI) begin
            nxt_resp_len = mb_pkg::WMR_RESP_LEN;
            nxt_state    = mb_pkg::ST_COPY;
          end else begin
            nxt_resp_len = mb_pkg::SPEC_RESP_LEN;
            nxt_start    = hdr_ff[3] == mb_pkg::CTL_START;
            nxt_stop     = hdr_ff[3] == mb_pkg::CTL_STOP;
            nxt_state    = mb_pkg::ST_SEND;
          end
        end
      end
      mb_pkg::ST_COPY: begin
        // Read, then write; two cycles per word
        nxt_copy_ph = !copy_ph_ff;
        if (copy_ph_ff) begin
          copy_we    = 1'b1;
          nxt_copy_i = copy_i_ff + 7'h01;
          if ({9'h000, nxt_copy_i} == reg_cnt) begin
            nxt_state = mb_pkg::ST_SEND;
          end
        end
      end
      mb_pkg::ST_SEND: begin
        tx_push = 1'b1;
        if (fifo_ready) begin
          nxt_tx_idx = tx_idx_ff + 3'h1;
          if (tx_idx_ff < resp_len_ff) begin
            nxt_tx_crc = mb_pkg::crc16_byte(tx_crc_ff, tx_byte);
          end
          if (tx_idx_ff == resp_len_ff + 3'h1) begin
            rx_clear  = 1'b1;
            nxt_state = mb_pkg::ST_RX;
          end
        end
      end
      default: begin
        nxt_state = mb_pkg::ST_RX;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff      <= mb_pkg::ST_RX;
      func_out_ff   <= 8'h00;
      exc_ff        <= 8'h00;
      is_exc_ff     <= 1'b0;
      resp_len_ff   <= 3'h0;
      tx_idx_ff     <= 3'h0;
      tx_crc_ff     <= mb_pkg::CRC_INIT;
      copy_i_ff     <= 7'h00;
      copy_ph_ff    <= 1'b0;
      start_ff      <= 1'b0;
      stop_ff       <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      func_out_ff   <= nxt_func_out;
      exc_ff        <= nxt_exc;
      is_exc_ff     <= nxt_is_exc;
      resp_len_ff   <= nxt_resp_len;
      tx_idx_ff     <= nxt_tx_idx;
      tx_crc_ff     <= nxt_tx_crc;
      copy_i_ff     <= nxt_copy_i;
      copy_ph_ff    <= nxt_copy_ph;
      start_ff      <= nxt_start;
      stop_ff       <= nxt_stop;
    end
  end

  assign o_motor_start = start_ff;
  assign o_motor_stop  = stop_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Storage and output queue
  logic [7:0]  mem_waddr;
  logic [15:0] mem_wdata;
  logic [7:0]  sp_wbase;

  // Staging keeps a rejected frame from touching live setpoints
  assign sp_wbase  = span[7:0] - reg_cnt[7:0];
  assign mem_waddr = copy_we ? sp_wbase + copy_addr : stg_addr;
  assign mem_wdata = copy_we ? rd_word_a : stg_data;

  sp_store u_store (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_we      (copy_we | stg_we),
    .i_waddr   (mem_waddr),
    .i_wdata   (mem_wdata),
    .i_raddr_a (mb_pkg::STG_BASE + copy_addr),
    .o_rdata_a (rd_word_a),
    .i_raddr_b ({1'b0, i_sp_rd_addr}),
    .o_rdata_b (o_sp_rd_data)
  );

  tx_fifo #(
    .WIDTH (mb_pkg::TX_WIDTH),
    .DEPTH (mb_pkg::TX_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_data   (tx_byte),
    .i_in_valid  (tx_push),
    .o_in_ready  (fifo_ready),
    .o_out_data  (o_tx_data),
    .o_out_valid (o_tx_valid),
    .i_out_ready (i_tx_ready)
  );

endmodule
`default_nettype wire

// >>> test/mb_chk.sv
// Port checker bound onto the frame handler
`default_nettype none
module mb_chk (
  input wire logic       i_clk,        // Clock
  input wire logic       i_sys_rst,    // Reset
  input wire logic [7:0] i_slave_addr, // Own address
  input wire logic [7:0] i_rx_data,    // Query byte
  input wire logic       i_rx_valid,   // Query strobe
  input wire logic       i_frame_end,  // Frame gap
  input wire logic       i_tx_ready,   // Reply taken
  input wire logic [7:0] o_tx_data,    // Reply byte
  input wire logic       o_tx_valid,   // Reply present
  input wire logic       o_motor_start,// Start pulse
  input wire logic       o_motor_stop  // Stop pulse
);
  logic [2:0] rx_ff, nxt_rx;
  logic [1:0] tx_ff, nxt_tx;
  logic [7:0] ad_ff, nxt_ad, fn_ff, nxt_fn, set_ff, nxt_set;
  wire  logic take = o_tx_valid && i_tx_ready;
  always_comb begin
    nxt_rx  = rx_ff;
    nxt_tx  = tx_ff;
    nxt_ad  = ad_ff;
    nxt_fn  = fn_ff;
    nxt_set = set_ff;
    if (i_frame_end) begin
      nxt_rx = 3'h0;
      nxt_tx = 2'h0;
    end else if (i_rx_valid) begin
      if (rx_ff == 3'h0) nxt_ad = i_rx_data;
      if (rx_ff == 3'h1) nxt_fn = i_rx_data;
      if (rx_ff == 3'h3) nxt_set = i_rx_data;
      if (rx_ff != 3'h4) nxt_rx = rx_ff + 3'h1;
    end
    if (take && tx_ff != 2'h2) nxt_tx = tx_ff + 2'h1;
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      {rx_ff, tx_ff, ad_ff, fn_ff, set_ff} <= '0;
    end else begin
      {rx_ff, tx_ff, ad_ff, fn_ff, set_ff} <=
        {nxt_rx, nxt_tx, nxt_ad, nxt_fn, nxt_set};
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_quiet;
    !o_tx_valid [*6];
  endsequence
  AST_EXCL: assert property (!(o_motor_start && o_motor_stop))
    else $error("start and stop together");
  AST_START_LAT: assert property (o_motor_start |->
    $past(i_frame_end, 2)) else $error("start slot");
  AST_START_CAUSE: assert property (o_motor_start |->
    fn_ff == mb_pkg::FN_SPECIAL && set_ff == mb_pkg::CTL_START)
    else $error("stray start");
  AST_STOP_CAUSE: assert property (o_motor_stop |->
    fn_ff == mb_pkg::FN_SPECIAL && set_ff == mb_pkg::CTL_STOP
    ##1 !o_motor_stop)
    else $error("bad stop pulse");
  AST_TX_HOLD: assert property (o_tx_valid && !i_tx_ready |=>
    o_tx_valid && $stable(o_tx_data)) else $error("reply byte dropped");
  AST_FIRST_ADDR: assert property (take && tx_ff == 2'h0 |->
    o_tx_data == i_slave_addr) else $error("reply address wrong");
  AST_FN_ECHO: assert property (take && tx_ff == 2'h1 |->
    o_tx_data[6:0] == fn_ff[6:0]) else $error("function field wrong");
  AST_DROP: assert property (i_frame_end && !o_tx_valid &&
    ad_ff != i_slave_addr |=> s_quiet) else $error("foreign frame answered");
endmodule
bind modbus_slave_frame_handler mb_chk u_mb_chk (.*);
`default_nettype wire

// >>> test/master_model.sv
// Serial master: sends queries, drains replies with stalls
`default_nettype none
module master_model (
  input  wire logic       i_clk,      // Clock
  input  wire logic       i_front,    // Front port order
  input  wire logic [7:0] i_tx_data,  // Reply byte
  input  wire logic       i_tx_valid, // Reply present
  output var  logic [7:0] o_rx_data,  // Query byte
  output var  logic       o_rx_valid, // Query strobe
  output var  logic       o_fend,     // Frame gap
  output var  logic       o_tx_ready  // Reply taken
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  initial {o_rx_data, o_rx_valid, o_fend, o_tx_ready} = '0;
  // Stalls back-pressure the reply FIFO
  always @(negedge i_clk) o_tx_ready <= ($urandom % 3) != 0;
  always @(posedge i_clk)
    if (i_tx_valid && o_tx_ready) got.push_back(i_tx_data);
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc(q) ^ {15'h0000, bad};
    q.push_back(i_front ? c[15:8] : c[7:0]);
    q.push_back(i_front ? c[7:0] : c[15:8]);
    foreach (q[i]) begin
      @(negedge i_clk);
      o_rx_data = q[i];
      o_rx_valid = 1'b1;
      @(negedge i_clk);
      o_rx_valid = 1'b0;
      o_rx_data = ~q[i];
    end
    o_fend = 1'b1;
    @(negedge i_clk);
    o_fend = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> test/tb.sv
// Bench: queries against a reply model
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, front, busy, nak, rxv, fend, txr, txv, mst, msp;
  logic [7:0] sa, rxd, txd;
  logic [6:0] rda;
  logic [15:0] rdd;
  int fails, cmp_count, st, sp, est, esp;
  int mem [128];
  logic [7:0] q[$];
  modbus_slave_frame_handler u_modbus_slave_frame_handler (.i_clk(clk),
    .i_sys_rst(rst), .i_slave_addr(sa), .i_front_port(front),
    .i_rx_data(rxd), .i_rx_valid(rxv), .i_frame_end(fend), .i_busy(busy),
    .i_nak(nak), .i_tx_ready(txr), .o_tx_data(txd), .o_tx_valid(txv),
    .o_motor_start(mst), .o_motor_stop(msp), .i_sp_rd_addr(rda),
    .o_sp_rd_data(rdd));
  master_model u_master (.i_clk(clk), .i_front(front), .i_tx_data(txd),
    .i_tx_valid(txv), .o_rx_data(rxd), .o_rx_valid(rxv), .o_fend(fend),
    .o_tx_ready(txr));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    st += int'(mst === 1'b1);
    sp += int'(msp === 1'b1);
  end
  task automatic cmp(input logic [15:0] g, e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic results;
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic wmr(input int s, c, input bit trip);
    logic [15:0] v;
    q = {sa, 8'h10, 8'(s >> 8), 8'(s), 8'h00, 8'(c), 8'(2 * c)};
    for (int i = 0; i < c; i++) begin
      v = ($urandom % 4 == 0) ? 16'hffff : 16'($urandom % 16'h2711);
      if (trip && i == c - 1) v = 16'h2711;
      q.push_back(v[15:8]);
      q.push_back(v[7:0]);
    end
  endtask
  task automatic run(input logic bad = 1'b0);
    logic [7:0] r[$];
    logic [15:0] x;
    int c, s, e, k;
    c = {q[4], q[5]};
    s = {q[2], q[3]};
    e = 0;
    if (q[1] != 8'h10 && q[1] != 8'h09) e = 1;
    else if (busy) e = 6;
    else if (q[1] == 8'h09) begin
      if (q.size() != 4) e = 3;
      else if (q[2] != 8'h30) e = 1;
      else if (q[3] != 8'h1a && q[3] != 8'h1b) e = 3;
    end else if (c > 125) e = 16;
    else if (c == 0 || q[6] != 2 * c || q.size() != 7 + 2 * c)
      e = 3;
    else if (s < 1000 || s + c > 1128) e = 2;
    else for (k = 0; k < c; k++)
      if ({q[7+2*k], q[8+2*k]} inside {[16'h2711:16'hfffe]})
        e = 3;
    if (e == 0 && nak) e = 7;
    if (!bad && q[0] == sa) begin
      if (e != 0) r = {q[0], q[1] | 8'h80, 8'(e)};
      else r = q[0:(q[1] == 8'h10) ? 5 : 3];
      if (e == 0 && q[1] == 8'h10)
        for (k = 0; k < c; k++) mem[s - 1000 + k] = {q[7+2*k], q[8+2*k]};
      if (e == 0 && q[1] == 8'h09) begin
        est += int'(q[3] == 8'h1a);
        esp += int'(q[3] == 8'h1b);
      end
      x = u_master.crc(r);
      r.push_back(front ? x[15:8] : x[7:0]);
      r.push_back(front ? x[7:0] : x[15:8]);
    end
    u_master.send(q, bad);
    for (k = 0; k < 3000 && u_master.got.size() < r.size(); k++)
      @(negedge clk);
    if (k == 3000) begin
      fails++;
      results();
    end
    repeat (30) @(negedge clk);
    cmp(16'(u_master.got.size()), 16'(r.size()));
    foreach (r[i])
      if (i < u_master.got.size()) cmp(u_master.got[i], r[i]);
    cmp(16'(st), 16'(est));
    cmp(16'(sp), 16'(esp));
    u_master.got.delete();
  endtask
  initial begin
    void'($urandom(32'hecb8));
    {rst, front, busy, nak, rda} = {1'b1, 10'h000};
    sa = 8'(1 + $urandom % 247);
    foreach (mem[i]) mem[i] = -1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    q = {sa, 8'h09, 8'h30, 8'h1a};
    run();
    front = 1'b1;
    q[3] = 8'h1b;
    run();
    q[2] = 8'h31;
    run();
    q = {sa, 8'h09, 8'h30, 8'h1c};
    run();
    busy = 1'b1;
    run();
    {busy, nak} = 2'b01;
    q[3] = 8'h1a;
    run();
    nak = 1'b0;
    q[0] = ~sa;
    run();
    q[0] = sa;
    run(1'b1);
    q = {sa, 8'h03, 8'h03, 8'he8, 8'h00, 8'h01};
    run();
    q = {sa, 8'h10, 8'h03, 8'he8, 8'h00, 8'h7e, 8'hfc};
    run();
    q = {sa, 8'h10, 8'h03, 8'he8, 8'h00, 8'h01, 8'h03, 8'h00, 8'h05};
    run();
    wmr(1000, 125, 1'b0);
    run();
    wmr(1127, 2, 1'b0);
    run();
    repeat (14) begin
      front = 1'($urandom % 2);
      busy = ($urandom % 8) == 0;
      nak = ($urandom % 8) == 0;
      wmr(990 + $urandom % 140, 1 + $urandom % 8, ($urandom % 5) == 0);
      run();
    end
    foreach (mem[i]) if (mem[i] >= 0) begin
      rda = 7'(i);
      @(negedge clk);
      cmp(rdd, 16'(mem[i]));
    end
    results();
  end
endmodule
`default_nettype wire
